// [core/dual_copy_regulator_config.sv]
// dual copy regulator configuration register bank
`timescale 1ns/1ns
module dual_copy_regulator_config (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [7:0] cmd_code,
   input wire logic wr_stb,
   input wire logic [7:0] wr_data,
   input wire logic rd_stb,
   output logic [7:0] rd_data,
   output logic rd_valid,
   input wire logic [7:0] vout_command,
   input wire logic [7:0] voltage_code_pins,
   input wire logic current_limit_timeout,
   output logic [7:0] voltage_code,
   output logic [2:0] phase_count,
   output logic loop_test_enable,
   output logic latchoff_enable,
   output logic latched_off,
   output logic config_locked,
   output logic [7:0] turn_on_delay_setting,
   output logic [7:0] turn_on_rise_setting
);
   typedef struct packed {
      logic [7:0] cfg_primary;
      logic [7:0] cfg_security;
      logic [7:0] on_delay;
      logic [7:0] on_rise;
      logic locked;
      logic [7:0] rd_data;
      logic rd_valid;
      logic [7:0] vcode;
      logic [2:0] phases;
      logic loop_test;
      logic latch_en;
      logic latched;
   } bank_s;

   bank_s st_r;
   bank_s st_nxt;
   logic rst_meta_r;
   logic rst_sync_r;
   logic rst_n;
   logic [7:0] pins_sync;
   logic [2:0] ph_a;
   logic [2:0] ph_b;

   // reset released through two flops, asserted at once
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   assign rst_n = rst_sync_r;

   pin_sync3 #(
      .W(8)
   ) u_pin_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pin_in(voltage_code_pins),
      .pin_out(pins_sync)
   );

   assign ph_a = st_r.cfg_primary[regcfg_pkg::PHASE_MSB:regcfg_pkg::PHASE_LSB];
   assign ph_b =
      st_r.cfg_security[regcfg_pkg::PHASE_MSB:regcfg_pkg::PHASE_LSB];

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rd_valid = 1'b0;

      // register writes; the lock freezes every lockable register
      if (wr_stb)
      begin
         unique case (cmd_code)
            regcfg_pkg::CMD_LOCK_RESET:
            begin
               if (!st_r.locked)
               begin
                  if (wr_data[regcfg_pkg::REG_RESET_BIT])
                  begin
                     st_nxt.cfg_primary = regcfg_pkg::RST_CFG;
                     st_nxt.cfg_security = regcfg_pkg::RST_CFG;
                     st_nxt.on_delay = regcfg_pkg::RST_ON_DELAY;
                     st_nxt.on_rise = regcfg_pkg::RST_ON_RISE;
                  end
                  // lock is write-once; only a power cycle clears it
                  st_nxt.locked = wr_data[regcfg_pkg::LOCK_BIT];
               end
            end
            regcfg_pkg::CMD_CFG_PRIMARY:
            begin
               if (!st_r.locked)
               begin
                  st_nxt.cfg_primary = wr_data;
               end
            end
            regcfg_pkg::CMD_CFG_SECURITY:
            begin
               if (!st_r.locked)
               begin
                  st_nxt.cfg_security = wr_data;
               end
            end
            regcfg_pkg::CMD_ON_DELAY:
            begin
               if (!st_r.locked)
               begin
                  st_nxt.on_delay = wr_data;
               end
            end
            regcfg_pkg::CMD_ON_RISE:
            begin
               if (!st_r.locked)
               begin
                  st_nxt.on_rise = wr_data;
               end
            end
            default:
            begin
               st_nxt.on_rise = st_r.on_rise;
            end
         endcase
      end

      // register reads, answered one cycle later
      if (rd_stb)
      begin
         st_nxt.rd_valid = 1'b1;
         unique case (cmd_code)
            regcfg_pkg::CMD_LOCK_RESET:
               st_nxt.rd_data = {7'h00, st_r.locked};
            regcfg_pkg::CMD_CFG_PRIMARY:
               st_nxt.rd_data = st_r.cfg_primary;
            regcfg_pkg::CMD_CFG_SECURITY:
               st_nxt.rd_data = st_r.cfg_security;
            regcfg_pkg::CMD_ON_DELAY:
               st_nxt.rd_data = st_r.on_delay;
            regcfg_pkg::CMD_ON_RISE:
               st_nxt.rd_data = st_r.on_rise;
            default:
               st_nxt.rd_data = regcfg_pkg::RD_UNMAPPED;
         endcase
      end

      // effective settings from the stored copies alone, so write order
      // never matters; bit 0 feeds nothing
      // phase: only agreeing legal codes move it, else hold last
      if (ph_a == ph_b && ph_a <= regcfg_pkg::PHASE_CODE_MAX)
      begin
         st_nxt.phases = ph_a + 3'h1;
      end

      if (st_r.cfg_primary[regcfg_pkg::SW_VSEL_BIT]
          && st_r.cfg_security[regcfg_pkg::SW_VSEL_BIT])
      begin
         st_nxt.vcode = vout_command;
      end
      else
      begin
         st_nxt.vcode = pins_sync;
      end

      st_nxt.loop_test = st_r.cfg_primary[regcfg_pkg::LOOP_TEST_BIT]
         && st_r.cfg_security[regcfg_pkg::LOOP_TEST_BIT];

      // disabled only when clear in both copies: fails safe
      st_nxt.latch_en = st_r.cfg_primary[regcfg_pkg::LATCHOFF_BIT]
         || st_r.cfg_security[regcfg_pkg::LATCHOFF_BIT];

      // latched state holds until power cycle
      if (current_limit_timeout && st_r.latch_en)
      begin
         st_nxt.latched = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r.cfg_primary <= regcfg_pkg::RST_CFG;
         st_r.cfg_security <= regcfg_pkg::RST_CFG;
         st_r.on_delay <= regcfg_pkg::RST_ON_DELAY;
         st_r.on_rise <= regcfg_pkg::RST_ON_RISE;
         st_r.locked <= 1'b0;
         st_r.rd_data <= regcfg_pkg::RD_UNMAPPED;
         st_r.rd_valid <= 1'b0;
         st_r.vcode <= regcfg_pkg::VCODE_RST;
         st_r.phases <= regcfg_pkg::PHASE_COUNT_RST;
         st_r.loop_test <= 1'b0;
         st_r.latch_en <= 1'b0;
         st_r.latched <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign rd_data = st_r.rd_data;
   assign rd_valid = st_r.rd_valid;
   assign voltage_code = st_r.vcode;
   assign phase_count = st_r.phases;
   assign loop_test_enable = st_r.loop_test;
   assign latchoff_enable = st_r.latch_en;
   assign latched_off = st_r.latched;
   assign config_locked = st_r.locked;
   assign turn_on_delay_setting = st_r.on_delay;
   assign turn_on_rise_setting = st_r.on_rise;
endmodule

// [core/regcfg_pkg.sv]
// constants for the dual copy regulator configuration bank
package regcfg_pkg;
   localparam logic [7:0] CMD_LOCK_RESET = 8'hd0;
   localparam logic [7:0] CMD_CFG_PRIMARY = 8'hd2;
   localparam logic [7:0] CMD_CFG_SECURITY = 8'hd3;
   localparam logic [7:0] CMD_ON_DELAY = 8'hd4;
   localparam logic [7:0] CMD_ON_RISE = 8'hd5;

   localparam logic [7:0] RST_CFG = 8'h72;
   localparam logic [7:0] RST_ON_DELAY = 8'h03;
   localparam logic [7:0] RST_ON_RISE = 8'h02;
   localparam logic [7:0] RST_LOCK_RESET = 8'h00;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // configuration field positions
   localparam int PHASE_MSB = 6;
   localparam int PHASE_LSB = 4;
   localparam int SW_VSEL_BIT = 3;
   localparam int LOOP_TEST_BIT = 2;
   localparam int LATCHOFF_BIT = 1;
   localparam int CFG_RSVD_BIT = 0;

   // lock / reset register fields
   localparam int REG_RESET_BIT = 1;
   localparam int LOCK_BIT = 0;

   localparam logic [2:0] PHASE_CODE_MAX = 3'h5;
   localparam logic [2:0] PHASE_COUNT_RST = 3'h1;
   localparam int VCODE_W = 8;
   localparam logic [VCODE_W-1:0] VCODE_RST = 8'h00;
endpackage

// [core/pin_sync3.sv]
// three stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync3 #(
   parameter int W = 8
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] held;
   } sync_s;

   sync_s st_r;
   sync_s st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.s1 = pin_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // only a level seen on two later stages counts
      if (st_r.s2 == st_r.s3)
      begin
         st_nxt.held = st_r.s3;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign pin_out = st_r.held;
endmodule

// [dv/host_model.sv]
// host model driving the configuration byte port
`timescale 1ns/1ns
module host_model (
   input wire logic ref_clk,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   output logic [7:0] cmd_code,
   output logic wr_stb,
   output logic [7:0] wr_data,
   output logic rd_stb
);
   initial
   begin
      cmd_code = 8'h00;
      wr_stb = 1'b0;
      wr_data = 8'h00;
      rd_stb = 1'b0;
   end
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      @(negedge ref_clk);
      cmd_code = c;
      wr_data = d;
      wr_stb = 1'b1;
      @(negedge ref_clk);
      wr_stb = 1'b0;
      // stale byte inverted so it never passes for a write
      wr_data = ~d;
   endtask
   task automatic wr_both(input logic [7:0] d);
      wr(8'hd2, d);
      wr(8'hd3, d);
   endtask
   task automatic rd(input logic [7:0] c, output logic [7:0] d);
      @(negedge ref_clk);
      cmd_code = c;
      rd_stb = 1'b1;
      @(negedge ref_clk);
      rd_stb = 1'b0;
      d = rd_valid ? rd_data : 8'hxx;
   endtask
endmodule

// [dv/regcfg_asserts.sv]
// port assertions for the configuration bank
`timescale 1ns/1ns
module regcfg_checker (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic rd_stb,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   input wire logic current_limit_timeout,
   input wire logic [2:0] phase_count,
   input wire logic latchoff_enable,
   input wire logic latched_off,
   input wire logic config_locked,
   input wire logic [7:0] turn_on_delay_setting,
   input wire logic [7:0] turn_on_rise_setting
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   rd_answer_a:
      assert property (rd_stb |=> rd_valid) else $error("read unanswered");
   rd_hold_a:
      assert property (!rd_valid |-> $stable(rd_data)) else $error("rd moved");
   phase_range_a:
      assert property (phase_count >= 3'h1 && phase_count <= 3'h6)
         else $error("phase count out of range");
   latch_set_a:
      assert property (current_limit_timeout && latchoff_enable |=> latched_off)
         else $error("timeout did not latch off");
   latch_keep_a:
      assert property (latched_off |=> latched_off) else $error("latch lost");
   latch_block_a:
      assert property (!latchoff_enable && !latched_off |=> !latched_off)
         else $error("latched while disabled");
   lock_keep_a:
      assert property (config_locked |=> config_locked) else $error("unlocked");
   lock_freeze_a:
      assert property (config_locked |=> $stable(turn_on_delay_setting)
         && $stable(turn_on_rise_setting))
         else $error("locked register changed");
endmodule
bind dual_copy_regulator_config regcfg_checker chk_u (.ref_clk, .reset_n,
   .rd_stb, .rd_data, .rd_valid, .current_limit_timeout, .phase_count,
   .latchoff_enable, .latched_off, .config_locked, .turn_on_delay_setting,
   .turn_on_rise_setting);

// [dv/tb.sv]
// self-checking bench for the dual copy configuration bank
`timescale 1ns/1ns
module tb;
   logic ref_clk, reset_n, wr_stb, rd_stb, rd_valid, current_limit_timeout;
   logic [7:0] cmd_code, wr_data, rd_data, vout_command, voltage_code_pins;
   logic [7:0] voltage_code, turn_on_delay_setting, turn_on_rise_setting;
   logic [2:0] phase_count;
   logic loop_test_enable, latchoff_enable, latched_off, config_locked;
   int failures = 0;
   int checks_done = 0;
   int cyc = 0;
   dual_copy_regulator_config dut_u (.ref_clk, .reset_n, .cmd_code, .wr_stb,
      .wr_data, .rd_stb, .rd_data, .rd_valid, .vout_command, .voltage_code_pins,
      .current_limit_timeout, .voltage_code, .phase_count, .loop_test_enable,
      .latchoff_enable, .latched_off, .config_locked, .turn_on_delay_setting,
      .turn_on_rise_setting);
   host_model host_u (.ref_clk, .rd_data, .rd_valid, .cmd_code, .wr_stb,
      .wr_data, .rd_stb);
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", n, e, g);
         failures++;
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic rdchk(input logic [7:0] c, input logic [7:0] e);
      logic [7:0] d;
      host_u.rd(c, d);
      chk("read", e, d);
   endtask
   task automatic t_reset();
      rdchk(8'hd2, 8'h72);
      rdchk(8'hd3, 8'h72);
      rdchk(8'hd4, 8'h03);
      rdchk(8'hd5, 8'h02);
      rdchk(8'hd1, 8'h00);
      chk("latchoff", 8'h01, {7'h0, latchoff_enable});
      chk("on_delay", 8'h03, turn_on_delay_setting);
      chk("on_rise", 8'h02, turn_on_rise_setting);
   endtask
   task automatic t_phase();
      for (int i = 0; i < 6; i++)
      begin
         host_u.wr_both({1'b0, i[2:0], 4'h0});
         idle(3);
         chk("phases", 8'(i + 1), {5'h0, phase_count});
      end
      host_u.wr(8'hd2, 8'h20);
      idle(3);
      chk("phases", 8'h06, {5'h0, phase_count});
   endtask
   task automatic t_vsel();
      host_u.wr(8'hd3, 8'h08);
      idle(3);
      chk("vcode", 8'ha5, voltage_code);
      host_u.wr(8'hd2, 8'h0c);
      idle(3);
      chk("vcode", 8'h3c, voltage_code);
      chk("loop", 8'h00, {7'h0, loop_test_enable});
      host_u.wr(8'hd3, 8'h05);
      voltage_code_pins = 8'h5a;
      idle(8);
      chk("loop", 8'h01, {7'h0, loop_test_enable});
      chk("vcode", 8'h5a, voltage_code);
      rdchk(8'hd3, 8'h05);
   endtask
   task automatic t_latch();
      chk("latchoff", 8'h00, {7'h0, latchoff_enable});
      current_limit_timeout = 1'b1;
      idle(2);
      chk("latched", 8'h00, {7'h0, latched_off});
      current_limit_timeout = 1'b0;
      host_u.wr(8'hd2, 8'h02);
      idle(3);
      current_limit_timeout = 1'b1;
      idle(1);
      current_limit_timeout = 1'b0;
      idle(1);
      chk("latched", 8'h01, {7'h0, latched_off});
   endtask
   task automatic t_lock();
      host_u.wr(8'hd4, 8'h55);
      host_u.wr(8'hd0, 8'h02);
      rdchk(8'hd4, 8'h03);
      host_u.wr(8'hd5, 8'h99);
      host_u.wr(8'hd0, 8'h01);
      host_u.wr(8'hd5, 8'h11);
      host_u.wr(8'hd0, 8'h02);
      rdchk(8'hd5, 8'h99);
      chk("on_rise", 8'h99, turn_on_rise_setting);
      chk("on_delay", 8'h03, turn_on_delay_setting);
      rdchk(8'hd0, 8'h01);
      chk("locked", 8'h01, {7'h0, config_locked});
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         failures++;
         stop_test();
      end
   end
   initial
   begin
      reset_n = 1'b0;
      vout_command = 8'h3c;
      voltage_code_pins = 8'ha5;
      current_limit_timeout = 1'b0;
      idle(4);
      reset_n = 1'b1;
      idle(4);
      t_reset();
      t_phase();
      t_vsel();
      t_latch();
      t_lock();
      stop_test();
   end
endmodule
